// [hdl/motor_drive_option_config.sv]
// Option registers and drive-side logic for a three-phase motor drive
`timescale 1ns/10ps
`default_nettype none
module motor_drive_option_config
  import motor_cfg_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int VDC_W = 12,
  parameter int PCNT_W = 23,
  parameter int PERSIST0_CYC = PERSIST0_MS * (NS_PER_MS / CLK_PERIOD_NS),
  parameter int PERSIST1_CYC = PERSIST1_MS * (NS_PER_MS / CLK_PERIOD_NS),
  parameter int PERSIST2_CYC = PERSIST2_MS * (NS_PER_MS / CLK_PERIOD_NS),
  parameter int PERSIST3_CYC = PERSIST3_MS * (NS_PER_MS / CLK_PERIOD_NS)
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic brake_pin,
  input wire logic dir_pin,
  input wire logic [2:0] pwm_demand,
  input wire logic pwm_en,
  input wire logic current_below,
  input wire logic bus_over_limit,
  input wire logic [VDC_W-1:0] vdc_raw,
  input wire logic vdc_valid,
  input wire logic motor_stopped,
  input wire logic detect_done,
  input wire logic reverse_done,
  output logic [14:0] closed_loop_slow_accel,
  output logic [VDC_W-1:0] vdc_meas,
  output logic bus_limit_active,
  output logic low_side_brake,
  output logic align_brake,
  output logic brake_met,
  output logic dir_ccw,
  output logic stop_req,
  output logic initial_speed_detect,
  output logic reverse_req,
  output logic phase_a_out_hi,
  output logic phase_a_out_lo,
  output logic phase_b_out_hi,
  output logic phase_b_out_lo,
  output logic phase_c_out_hi,
  output logic phase_c_out_lo
);
  typedef struct packed {
    logic [31:0] algo;
    logic [31:0] pin;
    logic [31:0] peri;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [1:0] brake_sync;
    logic [1:0] dir_sync;
    dir_state_t dir_st;
    logic applied_dir;
    logic stop_req;
    logic detect_req;
    logic rev_req;
    logic [14:0] accel;
    logic [VDC_W-1:0] vdc_filt;
    logic [VDC_W-1:0] vdc_out;
    logic lim_act;
    logic low_brake;
    logic align_brake;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic brake_req;
  logic dir_want;
  logic [2:0] leg_demand;
  logic leg_en;
  logic [5:0] dead_cycles;
  logic [2:0] hi_w;
  logic [2:0] lo_w;
  logic signed [VDC_W:0] vdc_diff;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // round dead time up
  assign dead_cycles = 6'((32'(st_ff.peri[DEAD_LSB +: 6]) * DEAD_STEP_NS
    + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Filter step; difference carries a sign bit
  assign vdc_diff = $signed({1'b0, vdc_raw}) - $signed({1'b0, st_ff.vdc_filt});

  always_comb
  begin
    unique case (st_ff.pin[BRAKE_SRC_LSB +: 2])
      2'h1: brake_req = 1'b1;
      2'h2: brake_req = 1'b0;
      default: brake_req = st_ff.brake_sync[1];
    endcase
  end

  always_comb
  begin
    unique case (st_ff.peri[DIR_SRC_LSB +: 2])
      2'h1: dir_want = 1'b0;
      2'h2: dir_want = 1'b1;
      default: dir_want = st_ff.dir_sync[1];
    endcase
  end

  // ----------------------------------------------------------------
  // Phase demand to the legs
  // ----------------------------------------------------------------
  // Braking outranks the direction sequence and the modulator
  always_comb
  begin
    leg_en = 1'b1;
    leg_demand = 3'h0;
    if (st_ff.low_brake)
      leg_demand = 3'h0;
    else if (st_ff.align_brake)
      leg_demand = 3'h1;
    else if (st_ff.dir_st == DIR_STOP || st_ff.dir_st == DIR_DETECT)
      leg_en = 1'b0;
    else
    begin
      leg_en = pwm_en;
      leg_demand = st_ff.applied_dir ?
        {pwm_demand[1], pwm_demand[2], pwm_demand[0]} : pwm_demand;
    end
  end

  // ----------------------------------------------------------------
  // Next state: bus, options, sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    // Pins pass two flops before anything reads them
    nxt_st.brake_sync = {st_ff.brake_sync[0], brake_pin};
    nxt_st.dir_sync = {st_ff.dir_sync[0], dir_pin};

    // Setup phase prepares the answer; access phase sees pready high
    nxt_st.ready = 1'b0;
    nxt_st.err = 1'b0;
    if (psel && !penable)
    begin
      nxt_st.ready = 1'b1;
      case (paddr)
        ALGO_OFFSET: nxt_st.rdata = st_ff.algo;
        PIN_OFFSET: nxt_st.rdata = st_ff.pin;
        PERI_OFFSET: nxt_st.rdata = st_ff.peri;
        default:
        begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.err = 1'b1;
        end
      endcase
    end

    if (psel && penable && st_ff.ready && pwrite)
    begin
      case (paddr)
        ALGO_OFFSET: nxt_st.algo = pwdata & ALGO_MASK;
        PIN_OFFSET: nxt_st.pin = pwdata & PIN_MASK;
        PERI_OFFSET: nxt_st.peri = pwdata & PERI_MASK;
        default: nxt_st.err = 1'b0;
      endcase
    end

    nxt_st.accel = accel_tenths(st_ff.algo[ACCEL_LSB +: 4]);

    if (vdc_valid)
    begin
      nxt_st.vdc_filt = VDC_W'(st_ff.vdc_filt
        + VDC_W'(vdc_diff >>> FILT_SHIFT));
      nxt_st.vdc_out = st_ff.pin[FILT_OFF_BIT] ? vdc_raw : nxt_st.vdc_filt;
    end

    nxt_st.lim_act = st_ff.peri[BUS_LIM_BIT] && bus_over_limit;

    nxt_st.low_brake = brake_req && !st_ff.pin[BRAKE_MODE_BIT];
    nxt_st.align_brake = brake_req && st_ff.pin[BRAKE_MODE_BIT];

    nxt_st.stop_req = 1'b0;
    nxt_st.detect_req = 1'b0;
    nxt_st.rev_req = 1'b0;
    unique case (st_ff.dir_st)
      DIR_RUN:
      begin
        if (dir_want != st_ff.applied_dir)
        begin
          if (st_ff.peri[DIR_MODE_BIT])
          begin
            nxt_st.dir_st = DIR_REVERSE;
            nxt_st.applied_dir = dir_want;
            nxt_st.rev_req = 1'b1;
          end
          else
          begin
            nxt_st.dir_st = DIR_STOP;
            nxt_st.stop_req = 1'b1;
          end
        end
      end
      DIR_STOP:
      begin
        nxt_st.stop_req = 1'b1;
        if (motor_stopped)
        begin
          // Direction is taken only once the rotor has stopped
          nxt_st.dir_st = DIR_DETECT;
          nxt_st.stop_req = 1'b0;
          nxt_st.applied_dir = dir_want;
          nxt_st.detect_req = 1'b1;
        end
      end
      DIR_DETECT:
      begin
        nxt_st.detect_req = !detect_done;
        if (detect_done)
          nxt_st.dir_st = DIR_RUN;
      end
      DIR_REVERSE:
      begin
        nxt_st.rev_req = !reverse_done;
        if (reverse_done)
          nxt_st.dir_st = DIR_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.algo <= ALGO_RESET;
      st_ff.pin <= PIN_RESET;
      st_ff.peri <= PERI_RESET;
      st_ff.dir_st <= DIR_RUN;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Leg drivers and brake timer
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 3; i++)
  begin : g_leg
    dead_time_gen #(
      .CNT_W(6)
    ) u_leg (
      .pclk(pclk),
      .presetn(presetn),
      .en(leg_en),
      .demand(leg_demand[i]),
      .dead_cycles(dead_cycles),
      .hi_on(hi_w[i]),
      .lo_on(lo_w[i])
    );
  end

  brake_persist #(
    .CNT_W(PCNT_W),
    .CYC0(PERSIST0_CYC),
    .CYC1(PERSIST1_CYC),
    .CYC2(PERSIST2_CYC),
    .CYC3(PERSIST3_CYC)
  ) u_persist (
    .pclk(pclk),
    .presetn(presetn),
    .active(st_ff.low_brake || st_ff.align_brake),
    .below(current_below),
    .sel(st_ff.algo[PERSIST_LSB +: 2]),
    .met(brake_met)
  );

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign closed_loop_slow_accel = st_ff.accel;
  assign vdc_meas = st_ff.vdc_out;
  assign bus_limit_active = st_ff.lim_act;
  assign low_side_brake = st_ff.low_brake;
  assign align_brake = st_ff.align_brake;
  assign dir_ccw = st_ff.applied_dir;
  assign stop_req = st_ff.stop_req;
  assign initial_speed_detect = st_ff.detect_req;
  assign reverse_req = st_ff.rev_req;
  assign phase_a_out_hi = hi_w[0];
  assign phase_a_out_lo = lo_w[0];
  assign phase_b_out_hi = hi_w[1];
  assign phase_b_out_lo = lo_w[1];
  assign phase_c_out_hi = hi_w[2];
  assign phase_c_out_lo = lo_w[2];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  accel_table_a: assert property (
    st_ff.algo[ACCEL_LSB +: 4] == 4'hF ##1 $stable(st_ff.algo)
      |-> st_ff.accel == ACCEL_MAX)
    else $error("ramp rate does not follow code F");
  filter_bypass_a: assert property (
    st_ff.pin[FILT_OFF_BIT] && vdc_valid |=> vdc_meas == $past(vdc_raw))
    else $error("bus voltage not bypassed");
  brake_mode_a: assert property (
    st_ff.pin[BRAKE_SRC_LSB +: 2] == 2'h1 && !st_ff.pin[BRAKE_MODE_BIT]
      |=> st_ff.low_brake && !st_ff.align_brake)
    else $error("low-side brake not applied");
  no_brake_a: assert property (
    st_ff.pin[BRAKE_SRC_LSB +: 2] == 2'h2
      |=> !st_ff.low_brake && !st_ff.align_brake)
    else $error("brake applied while overridden off");
  bus_limit_a: assert property (
    !st_ff.peri[BUS_LIM_BIT] |=> !st_ff.lim_act)
    else $error("bus limit active while disabled");
  dir_force_a: assert property (
    st_ff.dir_st == DIR_RUN && !st_ff.applied_dir
      && st_ff.peri[DIR_SRC_LSB +: 2] == 2'h2 |=> st_ff.dir_st != DIR_RUN)
    else $error("forced reverse order ignored");
  dir_policy_a: assert property (
    $rose(st_ff.rev_req) |-> $past(st_ff.peri[DIR_MODE_BIT])
      && $past(st_ff.dir_st) == DIR_RUN)
    else $error("reverse drive without policy bit");
  dir_stop_a: assert property (
    $rose(st_ff.stop_req) |-> !$past(st_ff.peri[DIR_MODE_BIT]))
    else $error("stop sequence with reverse policy");
  legs_off_a: assert property (
    st_ff.dir_st == DIR_STOP && !st_ff.low_brake && !st_ff.align_brake
      |=> hi_w == 3'h0)
    else $error("high side driven while stopping");
  reserved_zero_a: assert property (
    st_ff.ready |-> (st_ff.rdata & ~(ALGO_MASK | PIN_MASK | PERI_MASK)) == 0)
    else $error("reserved bits read non-zero");
  apb_answer_a: assert property (
    psel && !penable |=> pready ##1 !pready || (psel && !penable))
    else $error("apb answer timing broken");

  rev_c: cover property (st_ff.dir_st == DIR_REVERSE ##1 reverse_done);
  detect_c: cover property (st_ff.dir_st == DIR_STOP ##1 st_ff.detect_req);
  align_c: cover property (st_ff.align_brake && brake_met);
  slverr_c: cover property (pready && pslverr);
endmodule
`default_nettype wire

// [inc/motor_cfg_pkg.sv]
// Constants, types and helpers shared by the motor drive option block
// ----------------------------------------------------------------------
// Contract
// - Four-bit code picks closed-loop ramp rate while estimator unaligned.
// - Two-bit code picks brake current-below persistence: 50/100/250/500 ms.
// - Bus voltage filtered unless filter-off bit set; then raw value used.
// - Brake mode bit: clear gives low-side braking, set gives align braking.
// - Brake source: 0/3 follow pin, 1 brake per mode, 2 never brake.
// - Dead time between phase high and low drive is code times 50 ns; the legs give that rounded up to whole 100 ns clocks plus one clock.
// - Bus current limiting acts only while its enable bit is set.
// - Direction source: 0/3 follow pin, 1 forces A-B-C, 2 forces A-C-B.
// - Direction change: bit clear stops then speed detect; set reverses.
// ----------------------------------------------------------------------
`default_nettype none
package motor_cfg_pkg;
  // Register byte offsets
  localparam logic [11:0] ALGO_OFFSET = 12'h058;
  localparam logic [11:0] PIN_OFFSET = 12'h05C;
  localparam logic [11:0] PERI_OFFSET = 12'h060;
  // Reset values
  localparam logic [31:0] ALGO_RESET = 32'h0000_0000;
  localparam logic [31:0] PIN_RESET = 32'h0000_0000;
  localparam logic [31:0] PERI_RESET = 32'h0000_0000;
  // Writable bits; all others are reserved and read as zero
  localparam logic [31:0] ALGO_MASK = 32'h0000_03C3;
  localparam logic [31:0] PIN_MASK = 32'h0008_0007;
  localparam logic [31:0] PERI_MASK = 32'h0000_7E0F;
  // Field positions
  localparam int ACCEL_LSB = 6;
  localparam int PERSIST_LSB = 0;
  localparam int FILT_OFF_BIT = 19;
  localparam int BRAKE_MODE_BIT = 2;
  localparam int BRAKE_SRC_LSB = 0;
  localparam int DEAD_LSB = 9;
  localparam int BUS_LIM_BIT = 3;
  localparam int DIR_SRC_LSB = 1;
  localparam int DIR_MODE_BIT = 0;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEAD_STEP_NS = 50;
  localparam int NS_PER_MS = 1000000;
  localparam int PERSIST0_MS = 50;
  localparam int PERSIST1_MS = 100;
  localparam int PERSIST2_MS = 250;
  localparam int PERSIST3_MS = 500;
  // Bus voltage low-pass: new = old + (raw - old) / 8
  localparam int FILT_SHIFT = 3;
  localparam logic [14:0] ACCEL_MAX = 15'h4E20;

  typedef enum logic [1:0] {
    DIR_RUN = 2'b00,
    DIR_STOP = 2'b01,
    DIR_DETECT = 2'b10,
    DIR_REVERSE = 2'b11
  } dir_state_t;

  // Ramp rate in units of 0.1 Hz/s
  function automatic logic [14:0] accel_tenths(input logic [3:0] code);
    logic [14:0] r;
    r = 15'h0001;
    case (code)
      4'h0: r = 15'h0001;
      4'h1: r = 15'h000A;
      4'h2: r = 15'h0014;
      4'h3: r = 15'h001E;
      4'h4: r = 15'h0032;
      4'h5: r = 15'h0064;
      4'h6: r = 15'h00C8;
      4'h7: r = 15'h012C;
      4'h8: r = 15'h0190;
      4'h9: r = 15'h01F4;
      4'hA: r = 15'h03E8;
      4'hB: r = 15'h07D0;
      4'hC: r = 15'h1388;
      4'hD: r = 15'h1D4C;
      4'hE: r = 15'h2710;
      default: r = ACCEL_MAX;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// [hdl/dead_time_gen.sv]
// One phase leg: complementary drive with dead time inserted
`timescale 1ns/10ps
`default_nettype none
module dead_time_gen
  import motor_cfg_pkg::*;
#(
  parameter int CNT_W = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic demand,
  input wire logic [CNT_W-1:0] dead_cycles,
  output logic hi_on,
  output logic lo_on
);
  typedef struct packed {
    logic side;
    logic [CNT_W-1:0] cnt;
    logic hi;
    logic lo;
    logic [CNT_W:0] off_run;
  } leg_t;

  leg_t st_ff;
  leg_t nxt_st;

  // ----------------------------------------------------------------
  // Leg sequencing
  // ----------------------------------------------------------------
  // both off in gap
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.off_run = (st_ff.hi || st_ff.lo) ? '0 :
      ((&st_ff.off_run) ? st_ff.off_run : st_ff.off_run + 1'b1);
    if (!en || demand != st_ff.side)
    begin
      nxt_st.hi = 1'b0;
      nxt_st.lo = 1'b0;
      nxt_st.side = en ? demand : st_ff.side;
      nxt_st.cnt = dead_cycles;
    end
    else if (st_ff.cnt != '0)
    begin
      nxt_st.hi = 1'b0;
      nxt_st.lo = 1'b0;
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
    else
    begin
      nxt_st.hi = st_ff.side;
      nxt_st.lo = !st_ff.side;
    end
  end

  // State register; legs start switched off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign hi_on = st_ff.hi;
  assign lo_on = st_ff.lo;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  no_overlap_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(st_ff.hi && st_ff.lo))
    else $error("high and low side on together");
  dead_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(st_ff.hi) || $rose(st_ff.lo)) && $stable(dead_cycles)
      |-> st_ff.off_run >= {1'b0, $past(dead_cycles)})
    else $error("switch turned on before dead time elapsed");
endmodule
`default_nettype wire

// [hdl/brake_persist.sv]
// Timer for current below threshold while braking
`timescale 1ns/10ps
`default_nettype none
module brake_persist
  import motor_cfg_pkg::*;
#(
  parameter int CNT_W = 23,
  parameter int CYC0 = 500000,
  parameter int CYC1 = 1000000,
  parameter int CYC2 = 2500000,
  parameter int CYC3 = 5000000
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic below,
  input wire logic [1:0] sel,
  output logic met
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic met;
  } persist_t;

  persist_t st_ff;
  persist_t nxt_st;
  logic [CNT_W-1:0] limit;

  always_comb
  begin
    unique case (sel)
      2'h0: limit = CNT_W'(CYC0);
      2'h1: limit = CNT_W'(CYC1);
      2'h2: limit = CNT_W'(CYC2);
      2'h3: limit = CNT_W'(CYC3);
    endcase
  end

  // Any current above threshold restarts the wait
  always_comb
  begin
    nxt_st = st_ff;
    if (!(active && below))
    begin
      nxt_st.cnt = '0;
      nxt_st.met = 1'b0;
    end
    else if (st_ff.cnt >= limit - 1'b1)
      nxt_st.met = 1'b1;
    else
      nxt_st.cnt = st_ff.cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign met = st_ff.met;

  persist_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(active && below) |=> !st_ff.met)
    else $error("persistence met without low current");
  persist_early_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_ff.met) |-> $past(st_ff.cnt) >= limit - 1'b1)
    else $error("persistence met too early");
endmodule
`default_nettype wire

// [verification/motor_stage_model.sv]
// Power stage and motor algorithm stand-in facing the option block
`timescale 1ns/10ps
`default_nettype none
module motor_stage_model
#(
  parameter int LAG = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stop_req,
  input wire logic detect_req,
  input wire logic reverse_req,
  input wire logic [5:0] legs,
  output logic motor_stopped,
  output logic detect_done,
  output logic reverse_done,
  output int shoot_cnt
);
  int cnt;
  logic done;
  assign done = motor_stopped | detect_done | reverse_done;
  // stop, detect and reverse answered after a lag
  // counts cycles in which any leg has both switches on
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      motor_stopped <= 1'b0;
      detect_done <= 1'b0;
      reverse_done <= 1'b0;
      shoot_cnt <= 0;
    end
    else
    begin
      cnt <= ((stop_req | detect_req | reverse_req) && !done) ? cnt + 1 : 0;
      motor_stopped <= stop_req && cnt >= LAG;
      detect_done <= detect_req && cnt >= LAG;
      reverse_done <= reverse_req && cnt >= LAG;
      if ((legs[0] & legs[1]) | (legs[2] & legs[3]) | (legs[4] & legs[5]))
        shoot_cnt <= shoot_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// [verification/motor_drive_option_config_tb_top.sv]
// Self-checking bench for the motor drive option block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module motor_drive_option_config_tb_top;
  import motor_cfg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr, vdc_raw, vdc_meas;
  logic [31:0] pwdata, prdata, rd, v;
  logic brake_pin, dir_pin, pwm_en, current_below, bus_over_limit, vdc_valid;
  logic motor_stopped, detect_done, reverse_done, lim, lsb, alb, met, ccw;
  logic stop_req, speed_det, rev, saw_a, saw_b;
  logic [2:0] pwm_demand;
  logic [14:0] accel;
  logic [5:0] legs;
  int error_cnt, compares, seed, shoot_cnt, i, n, b;
  logic [31:0] shadow[3];
  logic [11:0] offs[3] = '{ALGO_OFFSET, PIN_OFFSET, PERI_OFFSET};
  logic [31:0] msk[3] = '{ALGO_MASK, PIN_MASK, PERI_MASK};
  int acc_tab[16] = '{1, 10, 20, 30, 50, 100, 200, 300, 400, 500, 1000,
    2000, 5000, 7500, 10000, 20000};
  int pers[4] = '{20, 40, 100, 200};

  // Design under test with short persistence counts
  motor_drive_option_config #(.PERSIST0_CYC(20), .PERSIST1_CYC(40),
    .PERSIST2_CYC(100), .PERSIST3_CYC(200)) motor_drive_option_config_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .brake_pin(brake_pin),
    .dir_pin(dir_pin), .pwm_demand(pwm_demand), .pwm_en(pwm_en),
    .current_below(current_below), .bus_over_limit(bus_over_limit),
    .vdc_raw(vdc_raw), .vdc_valid(vdc_valid), .motor_stopped(motor_stopped),
    .detect_done(detect_done), .reverse_done(reverse_done),
    .closed_loop_slow_accel(accel), .vdc_meas(vdc_meas),
    .bus_limit_active(lim), .low_side_brake(lsb), .align_brake(alb),
    .brake_met(met), .dir_ccw(ccw), .stop_req(stop_req),
    .initial_speed_detect(speed_det), .reverse_req(rev),
    .phase_a_out_hi(legs[0]), .phase_a_out_lo(legs[1]),
    .phase_b_out_hi(legs[2]), .phase_b_out_lo(legs[3]),
    .phase_c_out_hi(legs[4]), .phase_c_out_lo(legs[5]));

  // Far side of the drive
  motor_stage_model motor_stage_model_inst (.pclk(pclk), .presetn(presetn),
    .stop_req(stop_req), .detect_req(speed_det), .reverse_req(rev),
    .legs(legs),
    .motor_stopped(motor_stopped), .detect_done(detect_done),
    .reverse_done(reverse_done), .shoot_cnt(shoot_cnt));

  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // One APB transfer; a hang is left to the watchdog
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input int r, input logic [31:0] d);
    apb(offs[r], 1'b1, d);
    shadow[r] = d;
    tick(4);
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog sized well above the expected run
  initial
  begin
    tick(20000);
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, brake_pin, dir_pin} = '0;
    {pwm_demand, pwm_en, current_below, bus_over_limit, vdc_raw} = '0;
    vdc_valid = 1'b0;
    error_cnt = 0;
    compares = 0;
    seed = 43;
    shadow = '{default: '0};
    tick(12);
    presetn <= 1'b1;
    tick(3);
    for (i = 0; i < 2; i++)
    begin
      v = i ? 32'($random(seed)) : 32'h0000_0800;
      vdc_raw <= v[11:0];
      vdc_valid <= 1'b1;
      tick(1);
      vdc_valid <= 1'b0;
      tick(3);
      `CHK("vdc", i ? v[11:0] : 12'h100, vdc_meas)
      wr(1, 32'h0008_0000);
    end
    for (i = 0; i < 6; i++)
    begin
      if (i >= 3)
        wr(i - 3, 32'($random(seed)));
      apb(offs[i % 3], 1'b0, 32'h0);
      `CHK("regrd", shadow[i % 3] & msk[i % 3], rd)
      `CHK("slverr", 1'b0, er)
      // Idle edge so the next setup never re-drives psel in this step
      tick(1);
    end
    apb(12'h064, 1'b1, 32'hFFFF_FFFF);
    `CHK("unmapped", 1'b1, er)
    for (i = 0; i < 16; i++)
    begin
      wr(0, 32'(i) << 6);
      `CHK("accel", 15'(acc_tab[i]), accel)
    end
    // persistence per code, brake forced low side
    wr(1, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      wr(0, 32'(i));
      current_below <= 1'b1;
      n = 0;
      while (met !== 1'b1 && n < 300)
      begin
        tick(1);
        n++;
      end
      `CHK("persist", 1'b1, (n >= pers[i] && n <= pers[i] + 3))
      current_below <= 1'b0;
      tick(3);
    end
    // all source, mode and pin combinations
    for (i = 0; i < 16; i++)
    begin
      brake_pin <= i[3];
      wr(1, 32'(i[2:0]));
      b = (i[1:0] == 2'd1) || (i[1:0] != 2'd2 && i[3]);
      `CHK("lowbrk", b && !i[2], lsb)
      `CHK("alnbrk", b && i[2], alb)
    end
    bus_over_limit <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      wr(2, 32'(i) << 3);
      `CHK("buslim", i[0], lim)
    end
    // dead time code 5 gives at least three empty cycles
    wr(1, 32'h2);
    wr(2, 32'h5 << 9);
    pwm_en <= 1'b1;
    tick(10);
    pwm_demand <= 3'b001;
    n = 0;
    for (i = 0; i < 20; i++)
    begin
      tick(1);
      n += (legs[1:0] == 2'b00);
    end
    `CHK("deadgap", 1'b1, (n >= 3 && n <= 5))
    `CHK("ahigh", 1'b1, legs[0])
    `CHK("bclow", 4'b1010, legs[5:2])
    `CHK("shoot", 0, shoot_cnt)
    for (i = 0; i < 4; i++)
    begin
      dir_pin <= (i == 2);
      wr(2, (32'(2 - i % 2 - 2 * (i / 2) + 2 * (i / 3)) << 1) | 32'h1);
      saw_a = 1'b0;
      for (n = 0; n < 30; n++)
      begin
        tick(1);
        saw_a |= rev;
      end
      `CHK("revseen", 1'b1, saw_a)
      `CHK("ccw", (i % 2 == 0), ccw)
    end
    wr(2, 32'h4);
    {saw_a, saw_b} = 2'b00;
    for (n = 0; n < 60; n++)
    begin
      tick(1);
      saw_a |= stop_req;
      saw_b |= speed_det;
    end
    `CHK("stopisd", 2'b11, {saw_a, saw_b})
    `CHK("ccw", 1'b1, ccw)
    end_of_test();
  end
endmodule
`default_nettype wire
